// ---- core/swts_slot.sv ----
// single-wire thermometer slave: init handshake, time slots, function commands
`timescale 1ns/1ps
`default_nettype none
`include "swts_regs.svh"
module swts_slot #(
	parameter int RESET_CYC = `SWTS_RESET_CYC,
	parameter int PRES_WAIT_CYC = `SWTS_PRES_WAIT_CYC,
	parameter int PRES_LEN_CYC = `SWTS_PRES_LEN_CYC,
	parameter int MEAS_CYC = 30000,
	parameter int SAMPLE_CYC = `SWTS_SAMPLE_CYC,
	parameter int RD_HOLD_CYC = `SWTS_RD_HOLD_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// single-wire line, open drain
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_n_out,
	// device side
	input wire logic parasite_in,
	input wire logic [63:0] buf_lo_in,
	output logic [7:0] thr_high_out,
	output logic [7:0] thr_low_out,
	output logic meas_busy_out,
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out,
	input wire logic rx_ready_in
);
	// three-stage synchroniser; stage one read only by stage two
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			sync3_q <= 1'b1;
		end else if (ce_in) begin
			sync1_q <= line_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	logic fall;
	logic rise;
	assign fall = sync3_q && !sync2_q;
	assign rise = !sync3_q && sync2_q;

	// low-time counter for reset detect
	logic [`SWTS_CNT_W-1:0] low_q;
	logic reset_seen_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			low_q <= '0;
			reset_seen_q <= 1'b0;
		end else if (ce_in) begin
			if (sync2_q) begin
				low_q <= '0;
			end else if (low_q != '1) begin
				low_q <= low_q + 1'b1;
			end
			if (!sync2_q && low_q >= `SWTS_CNT_W'(RESET_CYC)) begin
				reset_seen_q <= 1'b1;
			end else if (rise) begin
				reset_seen_q <= 1'b0;
			end
		end
	end
	logic init_go;
	assign init_go = rise && reset_seen_q;

	// presence generator
	logic [`SWTS_CNT_W-1:0] pres_q;
	logic pres_wait_q;
	logic pres_drv_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pres_q <= '0;
			pres_wait_q <= 1'b0;
			pres_drv_q <= 1'b0;
		end else if (ce_in) begin
			if (init_go) begin
				pres_wait_q <= 1'b1;
				pres_drv_q <= 1'b0;
				pres_q <= '0;
			end else if (pres_wait_q) begin
				pres_q <= pres_q + 1'b1;
				if (pres_q == `SWTS_CNT_W'(PRES_WAIT_CYC - 1)) begin
					pres_wait_q <= 1'b0;
					pres_drv_q <= 1'b1;
					pres_q <= '0;
				end
			end else if (pres_drv_q) begin
				pres_q <= pres_q + 1'b1;
				if (pres_q == `SWTS_CNT_W'(PRES_LEN_CYC - 1)) begin
					pres_drv_q <= 1'b0;
				end
			end
		end
	end
	logic pres_busy;
	assign pres_busy = pres_wait_q || pres_drv_q;

	// slot timer from each falling edge outside presence
	logic [`SWTS_CNT_W-1:0] slot_q;
	logic in_slot_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			slot_q <= '0;
			in_slot_q <= 1'b0;
		end else if (ce_in) begin
			if (fall && !pres_busy) begin
				slot_q <= '0;
				in_slot_q <= 1'b1;
			end else if (in_slot_q) begin
				slot_q <= slot_q + 1'b1;
				if (slot_q == `SWTS_CNT_W'(SAMPLE_CYC)) begin
					in_slot_q <= 1'b0;
				end
			end
		end
	end
	logic sample_now;
	assign sample_now = in_slot_q && (slot_q == `SWTS_CNT_W'(SAMPLE_CYC));

	// phase machine
	swts_pkg::swts_phase_e phase_q;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [3:0] byte_q;
	logic byte_done;
	assign byte_done = sample_now && (bit_q == 3'h7);
	logic [7:0] rx_full;
	assign rx_full = {sync2_q, sh_q[7:1]};
	logic [7:0] skip_code;
	assign skip_code = 8'hCC;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			phase_q <= swts_pkg::ST_IDLE;
			sh_q <= '0;
			bit_q <= '0;
			byte_q <= '0;
		end else if (ce_in) begin
			if (init_go) begin
				phase_q <= swts_pkg::ST_ADDR;
				bit_q <= '0;
				byte_q <= '0;
			end else if (sample_now) begin
				bit_q <= bit_q + 1'b1;
				if (phase_q != swts_pkg::ST_RD_BUF) begin
					sh_q <= rx_full;
				end
				case (phase_q)
					swts_pkg::ST_ADDR: begin
						if (byte_done) begin
							phase_q <= (rx_full == skip_code) ? swts_pkg::ST_FUNC : swts_pkg::ST_SILENT;
						end
					end
					swts_pkg::ST_FUNC: begin
						if (byte_done) begin
							case (rx_full)
								`SWTS_CMD_RD_BUF: phase_q <= swts_pkg::ST_RD_BUF;
								`SWTS_CMD_WR_BUF: phase_q <= swts_pkg::ST_WR_BUF;
								`SWTS_CMD_CONVERT, `SWTS_CMD_RESTORE, `SWTS_CMD_SUPPLY: begin
									phase_q <= swts_pkg::ST_STATUS;
								end
								default: phase_q <= swts_pkg::ST_SILENT;
							endcase
						end
					end
					swts_pkg::ST_WR_BUF: begin
						if (byte_done) begin
							byte_q <= byte_q + 1'b1;
							if (byte_q == 4'h1) begin
								phase_q <= swts_pkg::ST_SILENT;
							end
						end
					end
					swts_pkg::ST_RD_BUF: begin
						if (byte_done) begin
							byte_q <= byte_q + 1'b1;
							if (byte_q == `SWTS_IDX_CRC) begin
								phase_q <= swts_pkg::ST_SILENT;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
	logic [7:0] cmd_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cmd_q <= '0;
		end else if (ce_in && phase_q == swts_pkg::ST_FUNC && byte_done) begin
			cmd_q <= rx_full;
		end
	end
	logic cmd_taken;
	assign cmd_taken = ce_in && phase_q == swts_pkg::ST_FUNC && byte_done;

	// thresholds, storage, restore and measurement timers
	swts_pkg::swts_thr_s work_q;
	swts_pkg::swts_thr_s nv_q;
	logic [15:0] rest_q;
	logic [`SWTS_CNT_W-1:0] meas_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			nv_q <= '0;
			work_q <= '0;
			rest_q <= `SWTS_RESTORE_CYC;
			meas_q <= '0;
		end else if (ce_in) begin
			if (rest_q != '0) begin
				rest_q <= rest_q - 1'b1;
				if (rest_q == 16'h0001) begin
					work_q <= nv_q;
				end
			end
			if (meas_q != '0) begin
				meas_q <= meas_q - 1'b1;
			end
			if (cmd_taken && rx_full == `SWTS_CMD_RESTORE) begin
				rest_q <= `SWTS_RESTORE_CYC;
			end
			if (cmd_taken && rx_full == `SWTS_CMD_COPY) begin
				nv_q <= work_q;
			end
			if (cmd_taken && rx_full == `SWTS_CMD_CONVERT) begin
				meas_q <= `SWTS_CNT_W'(MEAS_CYC);
			end
			if (phase_q == swts_pkg::ST_WR_BUF && byte_done) begin
				if (byte_q == 4'h0) begin
					work_q.high <= rx_full;
				end else begin
					work_q.low <= rx_full;
				end
			end
		end
	end

	// outbound bit for read slots
	function automatic logic [7:0] buf_byte(input logic [3:0] idx, input logic [63:0] lo,
		input swts_pkg::swts_thr_s t);
		logic [7:0] b;
		b = lo[8*idx[2:0] +: 8];
		if (idx == `SWTS_IDX_HIGH) b = t.high;
		if (idx == `SWTS_IDX_LOW) b = t.low;
		if (idx == `SWTS_IDX_CRC) b = 8'h00;
		return b;
	endfunction : buf_byte
	logic tx_bit;
	logic [7:0] tx_byte;
	assign tx_byte = buf_byte(byte_q, buf_lo_in, work_q);
	always_comb begin
		tx_bit = 1'b1;
		case (phase_q)
			swts_pkg::ST_RD_BUF: tx_bit = tx_byte[bit_q];
			swts_pkg::ST_STATUS: begin
				if (cmd_q == `SWTS_CMD_SUPPLY) tx_bit = !parasite_in;
				else if (cmd_q == `SWTS_CMD_RESTORE) tx_bit = (rest_q == '0);
				else tx_bit = parasite_in || (meas_q == '0);
			end
			default: tx_bit = 1'b1;
		endcase
	end
	logic rd_drv_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rd_drv_q <= 1'b0;
		end else if (ce_in) begin
			if (init_go) begin
				rd_drv_q <= 1'b0;
			end else if (fall && !pres_busy && !tx_bit) begin
				rd_drv_q <= 1'b1;
			end else if (in_slot_q && slot_q == `SWTS_CNT_W'(RD_HOLD_CYC)) begin
				rd_drv_q <= 1'b0;
			end
		end
	end

	// registered outputs; oe low means driving low
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	// one-cycle pulse per byte; a held valid would deadlock the pop
	assign fifo_pop = fifo_valid && rx_ready_in && !rx_valid_out;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			line_out <= 1'b0;
			line_oe_n_out <= 1'b1;
			thr_high_out <= '0;
			thr_low_out <= '0;
			meas_busy_out <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_byte_out <= '0;
		end else if (ce_in) begin
			line_oe_n_out <= !(pres_drv_q || rd_drv_q);
			thr_high_out <= work_q.high;
			thr_low_out <= work_q.low;
			meas_busy_out <= (meas_q != '0);
			rx_valid_out <= fifo_pop;
			if (fifo_pop) begin
				rx_byte_out <= fifo_data;
			end
		end
	end

	// received write bytes buffered toward the user side
	swts_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.flush_in(1'b0),
		.in_valid_in(phase_q == swts_pkg::ST_WR_BUF && byte_done),
		.in_ready_out(),
		.in_data_in(rx_full),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_data)
	);

	cover_pres_c: cover property (@(posedge clk_in) disable iff (!rstn_in) $fell(pres_wait_q) && pres_drv_q);
	cover_wr_c: cover property (@(posedge clk_in) disable iff (!rstn_in) phase_q == swts_pkg::ST_WR_BUF && byte_done && byte_q == 4'h1);
	cover_rd_c: cover property (@(posedge clk_in) disable iff (!rstn_in) phase_q == swts_pkg::ST_RD_BUF && rd_drv_q);

	presence_delay_a: assert property (@(posedge clk_in) disable iff (!rstn_in || !ce_in) init_go |-> !pres_drv_q [*8]) else $error("presence too early");
	presence_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in) $rose(pres_drv_q) |-> $past(pres_wait_q)) else $error("presence without wait");
	reset_abort_a: assert property (@(posedge clk_in) disable iff (!rstn_in) init_go && ce_in |=> phase_q == swts_pkg::ST_ADDR && !rd_drv_q) else $error("reset not aborting");
	drive_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in) rd_drv_q |-> slot_q <= `SWTS_CNT_W'(RD_HOLD_CYC)) else $error("read drive too long");
	read_in_slot_a: assert property (@(posedge clk_in) disable iff (!rstn_in) $rose(rd_drv_q) |-> $past(fall)) else $error("drive outside slot");
	copy_store_a: assert property (@(posedge clk_in) disable iff (!rstn_in) cmd_taken && rx_full == `SWTS_CMD_COPY |=> nv_q == $past(work_q)) else $error("copy lost");
	restore_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in) ce_in && rest_q == 16'h0001 && !cmd_taken |=> work_q == $past(nv_q) || phase_q == swts_pkg::ST_WR_BUF) else $error("restore lost");
	supply_bit_a: assert property (@(posedge clk_in) disable iff (!rstn_in) phase_q == swts_pkg::ST_STATUS && cmd_q == `SWTS_CMD_SUPPLY |-> tx_bit == !parasite_in) else $error("supply bit wrong");
	order_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in) $changed(phase_q) && phase_q == swts_pkg::ST_ADDR |-> $past(init_go)) else $error("order skipped");
endmodule : swts_slot
`default_nettype wire

// ---- core/swts_regs.svh ----
// timing constants and command codes for the single-wire sensor slot logic
`ifndef SWTS_REGS_SVH
`define SWTS_REGS_SVH
`define SWTS_CLK_MHZ 40
`define SWTS_RESET_MIN_US 480
`define SWTS_RESET_CYC (`SWTS_RESET_MIN_US * `SWTS_CLK_MHZ)
`define SWTS_PRES_WAIT_US 30
`define SWTS_PRES_WAIT_CYC (`SWTS_PRES_WAIT_US * `SWTS_CLK_MHZ)
`define SWTS_PRES_LEN_US 120
`define SWTS_PRES_LEN_CYC (`SWTS_PRES_LEN_US * `SWTS_CLK_MHZ)
`define SWTS_SAMPLE_US 30
`define SWTS_SAMPLE_CYC (`SWTS_SAMPLE_US * `SWTS_CLK_MHZ)
`define SWTS_RD_HOLD_US 15
`define SWTS_RD_HOLD_CYC (`SWTS_RD_HOLD_US * `SWTS_CLK_MHZ)
`define SWTS_CNT_W 16
`define SWTS_CMD_CONVERT 8'h44
`define SWTS_CMD_RD_BUF 8'hBE
`define SWTS_CMD_WR_BUF 8'h4E
`define SWTS_CMD_COPY 8'h48
`define SWTS_CMD_RESTORE 8'hB8
`define SWTS_CMD_SUPPLY 8'hB4
`define SWTS_BUF_BYTES 9
`define SWTS_IDX_HIGH 4'h2
`define SWTS_IDX_LOW 4'h3
`define SWTS_IDX_CRC 4'h8
`define SWTS_RESTORE_CYC 16'h0100
`endif

// ---- core/swts_pkg.sv ----
// types for the single-wire sensor slot logic
package swts_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_FUNC, ST_WR_BUF, ST_RD_BUF, ST_STATUS, ST_SILENT
	} swts_phase_e;
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} swts_thr_s;
endpackage : swts_pkg

// ---- core/swts_fifo.sv ----
// small flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module swts_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock, reset, clock enable and flush
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic flush_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	always_ff @(posedge clk_in) begin
		if (ce_in && push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (ce_in) begin
			if (flush_in) begin
				wr_q <= '0;
				rd_q <= '0;
				cnt_q <= '0;
			end else begin
				if (push) begin
					wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
				end
				if (pop) begin
					rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
				end
				cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end
endmodule : swts_fifo
`default_nettype wire

// ---- tb/swts_master.sv ----
// master-side partner model driving the single-wire line
`timescale 1ns/1ps
`default_nettype none
module swts_master #(
	parameter int RST_LOW_CYC = 480
) (
	// clock
	input wire logic clk_in,
	// line, pulled up when nobody pulls low
	input wire logic line_in,
	output logic drive_low_out
);
	initial begin
		drive_low_out = 1'b0;
	end
	// slot scaled to the shortened device counts, called at a falling clock edge
	task automatic slot(input logic bit_out, output logic bit_seen);
		drive_low_out = 1'b1;
		repeat (8) @(negedge clk_in);
		if (bit_out) begin
			drive_low_out = 1'b0;
		end
		repeat (12) @(negedge clk_in);
		bit_seen = line_in;
		repeat (80) @(negedge clk_in);
		drive_low_out = 1'b0;
		repeat (8) @(negedge clk_in);
	endtask : slot
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 0; i < 8; i++) begin
			slot(b[i], s);
		end
	endtask : send_byte
	// read slots only, lsb first
	task automatic recv_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			slot(1'b1, b[i]);
		end
	endtask : recv_byte
	// reset pulse, then samples before, during and after presence
	task automatic init(output logic early, output logic pres, output logic late);
		drive_low_out = 1'b1;
		repeat (RST_LOW_CYC) @(negedge clk_in);
		drive_low_out = 1'b0;
		repeat (20) @(negedge clk_in);
		early = line_in;
		repeat (65) @(negedge clk_in);
		pres = line_in;
		repeat (115) @(negedge clk_in);
		late = line_in;
	endtask : init
endmodule : swts_master
`default_nettype wire

// ---- tb/test_single_wire_sensor_slot_logic.sv ----
// self-checking bench for the single-wire sensor slot logic
`timescale 1ns/1ps
`default_nettype none
module test_single_wire_sensor_slot_logic;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic parasite_in = 1'b0;
	logic [63:0] buf_lo_in = 64'h0;
	logic rx_ready_in = 1'b0;
	logic ce_in = 1'b1;
	logic line, line_out, line_oe_n_out, m_low, meas_busy_out, rx_valid_out;
	logic [7:0] thr_high_out, thr_low_out, rx_byte_out;
	int miscompares = 0;
	int num_checks = 0;
	logic [7:0] exp_q[$];
	always #12.5 clk_in = ~clk_in;
	// open drain with pull-up: low if either side pulls
	assign line = (m_low || !line_oe_n_out) ? 1'b0 : 1'b1;
	swts_slot #(.RESET_CYC(400), .PRES_WAIT_CYC(40), .PRES_LEN_CYC(80), .SAMPLE_CYC(60),
		.RD_HOLD_CYC(30)) dut (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.line_in(line),
		.line_out(line_out),
		.line_oe_n_out(line_oe_n_out),
		.parasite_in(parasite_in),
		.buf_lo_in(buf_lo_in),
		.thr_high_out(thr_high_out),
		.thr_low_out(thr_low_out),
		.meas_busy_out(meas_busy_out),
		.rx_valid_out(rx_valid_out),
		.rx_byte_out(rx_byte_out),
		.rx_ready_in(rx_ready_in)
	);
	swts_master mstr (
		.clk_in(clk_in),
		.line_in(line),
		.drive_low_out(m_low)
	);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic start_cmd(input logic [7:0] addr, input logic [7:0] cmd);
		logic e, p, a;
		mstr.init(e, p, a);
		check(8'(e), 8'h01, "line before presence");
		check(8'(p), 8'h00, "presence");
		check(8'(a), 8'h01, "line after presence");
		mstr.send_byte(addr);
		mstr.send_byte(cmd);
	endtask : start_cmd
	// user side stalls at random to exercise the fifo
	always @(negedge clk_in) begin
		rx_ready_in <= ($urandom_range(0, 3) != 0);
	end
	// valid is a one-cycle pulse, looked at where it is settled
	always @(negedge clk_in) begin
		if (rx_valid_out === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(8'h01, 8'h00, "unexpected rx byte");
			end else begin
				check(rx_byte_out, exp_q.pop_front(), "rx byte");
			end
		end
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		miscompares++;
		$display("mismatch at %0t: run did not finish", $time);
		tally_and_finish();
	end
	initial begin
		logic b;
		logic [7:0] hi, lo, r, e;
		void'($urandom(20750));
		hi = 8'($urandom);
		lo = 8'($urandom);
		buf_lo_in = {$urandom, $urandom};
		parasite_in = 1'($urandom);
		repeat (3) @(negedge clk_in);
		rstn_in = 1'b1;
		repeat (300) @(negedge clk_in);
		check(thr_high_out, 8'h00, "power-up high");
		check(thr_low_out, 8'h00, "power-up low");
		check(8'(line_out), 8'h00, "line data level");
		// both bytes sent before the next reset, or storage may corrupt
		start_cmd(8'hCC, 8'h4E);
		exp_q.push_back(hi);
		mstr.send_byte(hi);
		exp_q.push_back(lo);
		mstr.send_byte(lo);
		check(thr_high_out, hi, "written high");
		check(thr_low_out, lo, "written low");
		// read four bytes, then cut the transfer short by a reset
		start_cmd(8'hCC, 8'hBE);
		for (int k = 0; k < 4; k++) begin
			mstr.recv_byte(r);
			e = (k == 2) ? hi : (k == 3) ? lo : buf_lo_in[8*k +: 8];
			check(r, e, "buffer byte");
		end
		start_cmd(8'hCC, 8'h48);
		mstr.slot(1'b1, b);
		check(8'(b), 8'h01, "copy silent");
		// overwrite the work copy so the restore is visible
		start_cmd(8'hCC, 8'h4E);
		exp_q.push_back(~hi);
		mstr.send_byte(~hi);
		exp_q.push_back(~lo);
		mstr.send_byte(~lo);
		check(thr_high_out, ~hi, "rewritten high");
		start_cmd(8'hCC, 8'hB8);
		mstr.slot(1'b1, b);
		check(8'(b), 8'h00, "restore running");
		repeat (300) @(negedge clk_in);
		mstr.slot(1'b1, b);
		check(8'(b), 8'h01, "restore status");
		check(thr_high_out, hi, "restored high");
		check(thr_low_out, lo, "restored low");
		start_cmd(8'hCC, 8'hB4);
		mstr.slot(1'b1, b);
		check(8'(b), 8'(!parasite_in), "supply mode");
		// external supply, so no strong pullup phase is needed
		parasite_in = 1'b0;
		start_cmd(8'hCC, 8'h44);
		mstr.slot(1'b1, b);
		check(8'(b), 8'h00, "measure status");
		check(8'(meas_busy_out), 8'h01, "measure busy");
		// addressing other than skip must leave the device silent
		start_cmd(8'h33, 8'hBE);
		mstr.slot(1'b1, b);
		check(8'(b), 8'h01, "silent after bad address");
		for (int n = 0; n < 200 && exp_q.size() != 0; n++) begin
			@(negedge clk_in);
		end
		check(8'(exp_q.size()), 8'h00, "rx bytes left");
		tally_and_finish();
	end
endmodule : test_single_wire_sensor_slot_logic
`default_nettype wire
